// [core/dfr_core.sv]
// Purpose: Frequency reference, DC braking, restart and stall logic of a motor inverter.
// Assumes: Output current in percent of inverter rated current; inputs synchronous.
// Notes: Power cycling is modelled by rst_i; ramp moves 0.1 Hz per ramp step.
// Behaviour
// R1 - Selector 0 to 14 picks a preset curve; 15 uses user curve words.
// R2 - Middle voltage is ignored when middle frequency equals minimum frequency.
// R3 - User curve frequencies must be ordered, else curve error flag.
// R4 - Motor rated current accepted only within 10 to 200 percent.
// R5 - No-load current limited to 0 to 99 percent of rated current.
// R6 - Slip added only above no-load current, scaled between no-load and rated.
// R7 - Rated slip 0.0 to 9.9 percent of voltage base; zero disables.
// R8 - No slip while command below minimum frequency or regenerating.
// R9 - Braking current output as percent of inverter rated current.
// R10 - Stop braking starts at the higher of start frequency and minimum.
// R11 - Zero start braking time starts directly at minimum frequency.
// R12 - Zero stop braking time blocks output below braking frequency.
// R13 - Command clamped between upper and lower bound percentages of maximum.
// R14 - Upper bound not above lower raises a limit setting error.
// R15 - Zero command runs at lower bound; below minimum frequency, no run; code blocks only the start, a running drive ramps to the lower bound.
// R16 - No steady run inside a jump band; ramps cross it smoothly.
// R17 - Jumping off when width is zero or all points are zero.
// R18 - Jump points must not increase, else jump setting error.
// R19 - Only over-current, ground fault, over-voltage may restart; others trip.
// R20 - Count restarts; clear after ten minutes normal, on reset after trip.
// R21 - Restart-selected output is on while a restart is in progress.
// R22 - Hold acceleration above accel level; decelerate above run level.
// R23 - Trip for good once restart count reaches the configured limit.
`timescale 1ns/1ps
module dfr_core #(
	parameter int TICK_CYCLES = dfr_pkg::TICK_CYC,
	parameter int RAMP_CYCLES = dfr_pkg::RAMP_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic run_i,
	input wire logic [15:0] freq_cmd_i,
	input wire logic [15:0] out_current_i,
	input wire logic regen_i,
	input wire logic fault_i,
	input wire logic [3:0] fault_code_i,
	input wire logic fault_reset_i,
	output logic [15:0] freq_o,
	output logic out_block_o,
	output logic dcbrake_o,
	output logic [15:0] dcbrake_current_o,
	output logic multifunc_o,
	output logic trip_o,
	output logic [2:0] setting_err_o
);
	import dfr_pkg::*;

	typedef struct packed {
		logic [NPRM-1:0][15:0] prm;
		dfr_state_type st;
		logic [15:0] freq;
		logic [15:0] outf;
		logic [15:0] rdata;
		logic [15:0] rcnt;
		logic [15:0] tmr;
		logic [15:0] okt;
		logic [31:0] div;
		logic [31:0] rdiv;
	} dfr_reg_type;

	dfr_reg_type r_ff;
	dfr_reg_type nxt_r;

	// Preset curve points: 0 to 7 on the lower base, 8 to 14 on the higher
	function automatic logic [15:0] preset_pt(input logic [3:0] sel, input int idx);
		logic [15:0] base;
		base = sel[3] ? PRESET_F60 : PRESET_F50;
		preset_pt = (idx >= 2) ? PRESET_FMIN : base;
	endfunction

	// Write limits keep settings inside their legal ranges
	function automatic logic [15:0] wclamp(input logic [7:0] a, input logic [15:0] d);
		wclamp = d;
		if (a == A_IRATED) begin
			if (d < IRATED_LO) wclamp = IRATED_LO; // see R4
			else if (d > IRATED_HI) wclamp = IRATED_HI; // see R4
		end else if (a == A_INOLOAD && d > INOLOAD_HI) begin
			wclamp = INOLOAD_HI; // see R5
		end else if (a == A_SLIP && d > SLIP_HI) begin
			wclamp = SLIP_HI; // see R7
		end
	endfunction

	// Percentage of a frequency, truncated
	function automatic logic [15:0] pct_of(input logic [15:0] f, input logic [15:0] p);
		logic [31:0] t;
		t = ({16'h0000, f} * {16'h0000, p}) / {16'h0000, PCT_FULL};
		pct_of = t[15:0];
	endfunction

	logic user_c;
	logic [15:0] fmax;
	logic [15:0] fvmax;
	logic [15:0] fmid;
	logic [15:0] fmin;
	logic [15:0] vmid;
	logic vf_err;
	logic lim_err;
	logic jmp_err;
	logic jmp_on;
	logic [15:0] ub;
	logic [15:0] lb;
	logic [15:0] tgt;
	logic norun;
	logic [15:0] fbrake;
	logic slip_on;
	logic [31:0] i0;
	logic [31:0] slip_hz;
	logic [31:0] comp;
	logic [31:0] fsum;
	logic tick;
	logic rtick;
	logic restartable;

	// Active curve selection and its checks
	always_comb begin
		user_c = r_ff.prm[A_VFSEL][3:0] == VF_USER;
		fmax = user_c ? r_ff.prm[A_FMAX] : preset_pt(r_ff.prm[A_VFSEL][3:0], 0); // see R1
		fvmax = user_c ? r_ff.prm[A_FVMAX] : preset_pt(r_ff.prm[A_VFSEL][3:0], 1); // see R1
		fmid = user_c ? r_ff.prm[A_FMID] : preset_pt(r_ff.prm[A_VFSEL][3:0], 2); // see R1
		fmin = user_c ? r_ff.prm[A_FMIN] : preset_pt(r_ff.prm[A_VFSEL][3:0], 3); // see R1
		vmid = (fmid == fmin || !user_c) ? 16'h0000 : r_ff.prm[A_VMID]; // see R2
		vf_err = user_c && !(fmax >= fvmax && fvmax >= fmid && fmid >= fmin); // see R3
		lim_err = r_ff.prm[A_UB] <= r_ff.prm[A_LB]; // see R14
		jmp_err = r_ff.prm[A_JP1] < r_ff.prm[A_JP1+1]
			|| r_ff.prm[A_JP1+1] < r_ff.prm[A_JP1+2]; // see R18
		jmp_on = r_ff.prm[A_JW] != 16'h0000 && (r_ff.prm[A_JP1] != 16'h0000
			|| r_ff.prm[A_JP1+1] != 16'h0000 || r_ff.prm[A_JP1+2] != 16'h0000); // see R17
	end

	// Frequency target: bounds, zero-command rule and jump bands
	always_comb begin
		logic [15:0] c;
		logic [15:0] hw;
		logic [15:0] lo;
		c = 16'h0000;
		hw = r_ff.prm[A_JW] >> 1;
		lo = 16'h0000;
		ub = pct_of(fmax, r_ff.prm[A_UB]); // see R13
		lb = pct_of(fmax, r_ff.prm[A_LB]); // see R13
		norun = freq_cmd_i == 16'h0000 && lb < fmin; // see R15
		if (freq_cmd_i == 16'h0000) c = lb; // see R15
		else if (freq_cmd_i > ub) c = ub; // see R13
		else if (freq_cmd_i < lb) c = lb; // see R13
		else c = freq_cmd_i;
		// Steady point is moved to the band's lower edge; the ramp itself never skips
		for (int k = 0; k < 3; k++) begin
			lo = (r_ff.prm[A_JP1+k] > hw) ? r_ff.prm[A_JP1+k] - hw : 16'h0000;
			if (jmp_on && c > lo && c < r_ff.prm[A_JP1+k] + hw) c = lo; // see R16
		end
		tgt = run_i ? c : 16'h0000;
		fbrake = (r_ff.prm[A_DCFREQ] < fmin) ? fmin : r_ff.prm[A_DCFREQ]; // see R10
	end

	// Slip compensation; the divide is wide but settles inside one cycle at this rate
	always_comb begin
		logic [31:0] den;
		den = 32'h00000000;
		i0 = ({16'h0000, r_ff.prm[A_INOLOAD]} * {16'h0000, r_ff.prm[A_IRATED]})
			/ {16'h0000, PCT_FULL};
		slip_hz = ({16'h0000, r_ff.prm[A_SLIP]} * {16'h0000, fvmax})
			/ {16'h0000, SLIP_FULL}; // see R7
		den = {16'h0000, r_ff.prm[A_IRATED]} - i0;
		slip_on = r_ff.st == ST_RUN && r_ff.prm[A_SLIP] != 16'h0000 // see R7
			&& {16'h0000, out_current_i} > i0 // see R6
			&& freq_cmd_i >= fmin && !regen_i; // see R8
		if (slip_on && den != 32'h00000000) begin
			comp = (slip_hz * ({16'h0000, out_current_i} - i0)) / den; // see R6
		end else begin
			comp = 32'h00000000;
		end
		fsum = {16'h0000, r_ff.freq} + comp;
	end

	// Dividers give the tenth-second tick and the ramp step enable
	assign tick = r_ff.div == 32'(TICK_CYCLES - 1);
	assign rtick = r_ff.rdiv == 32'(RAMP_CYCLES - 1);
	assign restartable = fault_code_i == FLT_OC || fault_code_i == FLT_GF
		|| fault_code_i == FLT_OV; // see R19

	// Next-state logic for the whole block
	always_comb begin
		nxt_r = r_ff;
		nxt_r.div = tick ? 32'h00000000 : r_ff.div + 32'h00000001;
		nxt_r.rdiv = rtick ? 32'h00000000 : r_ff.rdiv + 32'h00000001;
		nxt_r.outf = (fsum > 32'h0000FFFF) ? 16'hFFFF : fsum[15:0];
		// Register port: writes land at once, read data stand one cycle later
		if (wr_i && addr_i < 8'(NPRM)) begin
			nxt_r.prm[addr_i[4:0]] = wclamp(addr_i, wdata_i);
		end
		nxt_r.rdata = 16'h0000;
		if (rd_i) begin
			if (addr_i < 8'(NPRM)) nxt_r.rdata = r_ff.prm[addr_i[4:0]];
			else if (addr_i == A_STATUS)
				nxt_r.rdata = {9'h000, vmid != 16'h0000, r_ff.st, jmp_err, lim_err, vf_err};
			else if (addr_i == A_OUTF) nxt_r.rdata = r_ff.outf;
			else if (addr_i == A_RCNT) nxt_r.rdata = r_ff.rcnt;
		end
		// Normal running for the clear time forgets earlier restarts
		if (r_ff.st == ST_RUN && r_ff.rcnt != 16'h0000 && tick) begin
			nxt_r.okt = r_ff.okt + 16'h0001;
			if (r_ff.okt == OK_TICKS - 16'h0001) begin
				nxt_r.rcnt = 16'h0000; // see R20
				nxt_r.okt = 16'h0000;
			end
		end
		unique case (r_ff.st)
			ST_IDLE: begin
				nxt_r.freq = 16'h0000;
				if (run_i && !norun && !vf_err && !lim_err && !jmp_err) begin // see R15
					if (r_ff.prm[A_DCSTART] == 16'h0000) begin
						nxt_r.freq = fmin; // see R11
						nxt_r.st = ST_RUN;
					end else begin
						nxt_r.tmr = 16'h0000;
						nxt_r.st = ST_DCSTART;
					end
				end
			end
			ST_DCSTART: begin
				if (tick) nxt_r.tmr = r_ff.tmr + 16'h0001;
				if (!run_i) begin
					nxt_r.st = ST_IDLE;
				end else if (r_ff.tmr >= r_ff.prm[A_DCSTART]) begin
					nxt_r.freq = fmin;
					nxt_r.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (rtick) begin
					if (r_ff.freq < tgt) begin
						if (out_current_i <= r_ff.prm[A_ASTALL])
							nxt_r.freq = r_ff.freq + 16'h0001; // see R22
					end else if (r_ff.freq != 16'h0000 && (r_ff.freq > tgt
						|| out_current_i > r_ff.prm[A_RSTALL])) begin
						nxt_r.freq = r_ff.freq - 16'h0001; // see R22
					end
				end
				// Stopping: brake or block once at or below the braking frequency
				if (!run_i && r_ff.freq <= fbrake) begin // see R10
					nxt_r.freq = 16'h0000;
					nxt_r.tmr = 16'h0000;
					if (r_ff.prm[A_DCSTOP] == 16'h0000) nxt_r.st = ST_IDLE; // see R12
					else nxt_r.st = ST_DCSTOP;
				end
			end
			ST_DCSTOP: begin
				if (tick) nxt_r.tmr = r_ff.tmr + 16'h0001;
				if (r_ff.tmr >= r_ff.prm[A_DCSTOP]) nxt_r.st = ST_IDLE;
			end
			ST_RESTART: begin
				// Restart pause, then the normal start sequence resumes
				if (tick) nxt_r.tmr = r_ff.tmr + 16'h0001;
				if (r_ff.tmr >= RESTART_TICKS) nxt_r.st = ST_IDLE;
			end
			ST_TRIP: begin
				nxt_r.freq = 16'h0000;
				if (fault_reset_i) begin
					nxt_r.rcnt = 16'h0000; // see R20
					nxt_r.okt = 16'h0000;
					nxt_r.st = ST_IDLE;
				end
			end
		endcase
		// Faults override the sequence in any active state
		if (fault_i && r_ff.st != ST_TRIP) begin
			nxt_r.freq = 16'h0000;
			nxt_r.tmr = 16'h0000;
			nxt_r.okt = 16'h0000;
			if (restartable && r_ff.rcnt < r_ff.prm[A_RLIM]) begin // see R19
				nxt_r.rcnt = r_ff.rcnt + 16'h0001; // see R20
				nxt_r.st = ST_RESTART;
			end else begin
				nxt_r.st = ST_TRIP; // see R23
			end
		end
	end

	// State register; power-up clears the restart count too
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r_ff <= '0;
			r_ff.prm <= PRM_RST;
			r_ff.st <= ST_IDLE;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Outputs; braking current only while injecting
	always_comb begin
		rdata_o = r_ff.rdata;
		freq_o = r_ff.outf;
		dcbrake_o = r_ff.st == ST_DCSTART || r_ff.st == ST_DCSTOP;
		dcbrake_current_o = dcbrake_o ? r_ff.prm[A_DCCUR] : 16'h0000; // see R9
		out_block_o = !(r_ff.st == ST_RUN || dcbrake_o); // see R12
		trip_o = r_ff.st == ST_TRIP;
		setting_err_o = {jmp_err, lim_err, vf_err};
		if (r_ff.prm[A_MFOSEL] == MFO_RESTART) multifunc_o = r_ff.st == ST_RESTART; // see R21
		else if (r_ff.prm[A_MFOSEL] == MFO_TRIP) multifunc_o = trip_o;
		else multifunc_o = r_ff.st == ST_RUN;
	end
endmodule

// [dv/dfr_core_assertions.sv]
// Purpose: Port-level checks of the frequency reference block.
// Assumes: Parameter words change only through the register port.
// Notes: Clamped words 06h-08h are mirrored unclamped and not relied upon.
`timescale 1ns/1ps
module dfr_core_assertions
	import dfr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic run_i,
	input wire logic [15:0] freq_cmd_i,
	input wire logic fault_i,
	input wire logic [3:0] fault_code_i,
	input wire logic fault_reset_i,
	input wire logic out_block_o,
	input wire logic dcbrake_o,
	input wire logic [15:0] dcbrake_current_o,
	input wire logic multifunc_o,
	input wire logic trip_o,
	input wire logic [2:0] setting_err_o
);
	logic [15:0] prm [NPRM];
	logic go;
	logic ok_code;
	// Mirror of the parameter words, so flags can be predicted
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < NPRM; i++) begin
				prm[i] <= PRM_RST[i];
			end
		end else if (wr_i && addr_i < 8'h17) begin
			prm[addr_i[4:0]] <= wdata_i;
		end
	end
	// Idle start request; restart phase is only visible with selector 1
	assign go = out_block_o && !dcbrake_o && !trip_o && !multifunc_o && prm[22] == MFO_RESTART
		&& run_i && !fault_i && freq_cmd_i != 16'h0000 && setting_err_o == 3'h0;
	assign ok_code = fault_code_i inside {FLT_OC, FLT_GF, FLT_OV};
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_curve_err: assert property (setting_err_o[0] == (prm[0] == 16'h000F &&
		!(prm[1] >= prm[2] && prm[2] >= prm[3] && prm[3] >= prm[5]))) else $error("curve flag");
	chk_limit_err: assert property (setting_err_o[1] == (prm[13] <= prm[14]))
		else $error("limit flag");
	chk_jump_err: assert property (setting_err_o[2] != (prm[15] >= prm[16] &&
		prm[16] >= prm[17])) else $error("jump flag");
	chk_brake_level: assert property (dcbrake_current_o == (dcbrake_o ? prm[10] :
		16'h0000)) else $error("brake current");
	chk_brake_drive: assert property (dcbrake_o |-> !out_block_o)
		else $error("blocked while braking");
	chk_start_path: assert property (go |=> !out_block_o &&
		dcbrake_o == (prm[12] != 16'h0000)) else $error("start path");
	chk_zero_cmd: assert property (out_block_o && !dcbrake_o && run_i &&
		freq_cmd_i == 16'h0000 && prm[14] == 16'h0000 && prm[5] != 16'h0000 |=> out_block_o)
		else $error("ran at low bound");
	chk_restart_cause: assert property (prm[22] == MFO_RESTART && $rose(multifunc_o)
		|-> $past(fault_i) && $past(ok_code)) else $error("restart cause");
	chk_restart_hold: assert property (prm[22] == MFO_RESTART && $rose(multifunc_o)
		|-> multifunc_o [*8]) else $error("restart output short");
	chk_bad_fault: assert property (fault_i && !ok_code && !fault_reset_i |=> trip_o)
		else $error("no trip");
	chk_trip_clear: assert property (trip_o && fault_reset_i |=> !trip_o)
		else $error("trip held");
	cov_trip: cover property ($rose(trip_o));
	cov_brake: cover property ($rose(dcbrake_o));
	cov_restart: cover property (prm[22] == MFO_RESTART && $rose(multifunc_o));
endmodule
bind dfr_core dfr_core_assertions dfr_core_assertions_i (.clk_i, .rst_i, .addr_i, .wdata_i,
	.wr_i, .run_i, .freq_cmd_i, .fault_i, .fault_code_i, .fault_reset_i, .out_block_o,
	.dcbrake_o, .dcbrake_current_o, .multifunc_o, .trip_o, .setting_err_o);

// [dv/dfr_motor_model.sv]
// Purpose: Power stage and motor as seen from the frequency reference block.
// Assumes: Load current set by the bench, in percent of inverter rating.
// Notes: No motor dynamics; regeneration when demand falls or load overhauls.
`timescale 1ns/1ps
module dfr_motor_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] freq_i,
	input wire logic block_i,
	input wire logic [15:0] load_i,
	input wire logic overhaul_i,
	output logic [15:0] current_o,
	output logic regen_o
);
	logic [15:0] last_ff;
	// Last demand, to spot a falling frequency
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			last_ff <= 16'h0000;
		end else begin
			last_ff <= freq_i;
		end
	end
	// A blocked stage draws nothing, so stall logic cannot see stale load
	assign current_o = block_i ? 16'h0000 : load_i;
	assign regen_o = !block_i && (overhaul_i || freq_i < last_ff);
endmodule

// [dv/testbench.sv]
// Purpose: Self-checking bench of the frequency reference block.
// Assumes: Short tick and ramp counts; user curve 60.0 Hz max, 3.0 Hz min.
// Notes: Table rows cover clamped and unmapped parameter writes.
`timescale 1ns/1ps
module testbench;
	import dfr_pkg::*;
	typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] e;} dfr_row_type;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic run_i = 1'b0;
	logic [15:0] freq_cmd_i = 16'h0000;
	logic fault_i = 1'b0;
	logic [3:0] fault_code_i = 4'h0;
	logic fault_reset_i = 1'b0;
	logic [15:0] load = 16'h0032;
	logic overhaul = 1'b0;
	logic [15:0] rdata_o, freq_o, dcbrake_current_o, out_current_i;
	logic regen_i, out_block_o, dcbrake_o, multifunc_o, trip_o;
	logic [2:0] setting_err_o;
	int mismatches = 0;
	int n_tests = 0;
	int k;
	dfr_row_type rows [8] = '{
		'{A_IRATED, 16'h0005, 16'h000A}, '{A_IRATED, 16'h012C, 16'h00C8},
		'{A_IRATED, 16'h0064, 16'h0064}, '{A_INOLOAD, 16'h0078, 16'h0063},
		'{A_INOLOAD, 16'h0000, 16'h0000}, '{A_SLIP, 16'h00C8, 16'h0063},
		'{A_SLIP, 16'h0000, 16'h0000}, '{8'h17, 16'h1234, 16'h0000}};
	always #2 clk_i = ~clk_i;
	dfr_core #(.TICK_CYCLES(10), .RAMP_CYCLES(2)) dfr_core_i (.clk_i, .rst_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .run_i, .freq_cmd_i, .out_current_i, .regen_i,
		.fault_i, .fault_code_i, .fault_reset_i, .freq_o, .out_block_o, .dcbrake_o,
		.dcbrake_current_o, .multifunc_o, .trip_o, .setting_err_o);
	dfr_motor_model dfr_motor_model_i (.clk_i, .rst_i, .freq_i(freq_o), .block_i(out_block_o),
		.load_i(load), .overhaul_i(overhaul), .current_o(out_current_i), .regen_o(regen_i));
	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// One-cycle write; the word is live just after the second edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, e);
	endtask
	// Ramps are slow, so wait on the value under a bound
	task automatic wait_f(input logic [15:0] f);
		for (int i = 0; i < 2000 && freq_o !== f; i++) @(posedge clk_i) #1;
		chk(freq_o, f);
	endtask
	task automatic flt(input logic [3:0] c);
		@(posedge clk_i);
		fault_i <= 1'b1;
		fault_code_i <= c;
		@(posedge clk_i);
		fault_i <= 1'b0;
		cyc(1);
	endtask
	task automatic end_sim;
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
	initial begin
		cyc(5);
		@(posedge clk_i);
		rst_i <= 1'b0;
		for (k = 0; k < NPRM; k++) rdc(8'(k), PRM_RST[k]);
		rdc(A_STATUS, 16'h0000);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rdc(rows[i].a, rows[i].e);
		end
		// Settings errors and curve selection
		wr(A_UB, 16'h000A);
		wr(A_LB, 16'h0014);
		chk(16'(setting_err_o), 16'h0002);
		wr(A_LB, 16'h0000);
		wr(A_UB, 16'h0032);
		wr(A_JP1 + 8'h01, 16'h0064);
		chk(16'(setting_err_o), 16'h0004);
		wr(A_JP1 + 8'h01, 16'h0000);
		wr(A_VFSEL, 16'h000F);
		chk(16'(setting_err_o), 16'h0001);
		wr(A_VFSEL, 16'h000E);
		chk(16'(setting_err_o), 16'h0000);
		wr(A_FMID, 16'h001E);
		wr(A_VFSEL, 16'h000F);
		rdc(A_STATUS, 16'h0000);
		wr(A_FMID, 16'h0028);
		rdc(A_STATUS, 16'h0040);
		// Zero command: low bound below minimum, then above it
		@(posedge clk_i);
		run_i <= 1'b1;
		cyc(10);
		chk(16'(out_block_o), 16'h0001);
		wr(A_LB, 16'h000A);
		wait_f(16'h003C);
		freq_cmd_i <= 16'h01F4;
		wait_f(16'h012C);
		// Run stall, slip and regeneration
		load <= 16'h00B4;
		cyc(20);
		chk(16'(freq_o < 16'h012C), 16'h0001);
		load <= 16'h0032;
		wait_f(16'h012C);
		wr(A_SLIP, 16'h0032);
		cyc(3);
		chk(freq_o, 16'h013B);
		overhaul <= 1'b1;
		cyc(3);
		chk(freq_o, 16'h012C);
		overhaul <= 1'b0;
		wr(A_SLIP, 16'h0000);
		// Jump band, then both ways of turning it off
		wr(A_UB, 16'h0064);
		wr(A_JW, 16'h0014);
		wr(A_JP1, 16'h00C8);
		freq_cmd_i <= 16'h00C8;
		cyc(400);
		chk(16'(freq_o < 16'h00C8 && freq_o >= 16'h00B4), 16'h0001);
		wr(A_JW, 16'h0000);
		wait_f(16'h00C8);
		wr(A_JW, 16'h0014);
		wr(A_JP1, 16'h0000);
		cyc(5);
		chk(freq_o, 16'h00C8);
		// Zero stop time: output blocked near the brake frequency
		run_i <= 1'b0;
		for (k = 0; k < 1000 && out_block_o !== 1'b1; k++) @(posedge clk_i) #1;
		chk(16'(freq_o <= 16'h0033 && freq_o >= 16'h0031), 16'h0001);
		chk(16'(dcbrake_o), 16'h0000);
		// Start braking, stop braking from the minimum frequency
		wr(A_DCSTART, 16'h0002);
		wr(A_DCSTOP, 16'h0003);
		wr(A_DCCUR, 16'h0032);
		wr(A_DCFREQ, 16'h000A);
		run_i <= 1'b1;
		cyc(2);
		chk(16'(dcbrake_o), 16'h0001);
		chk(dcbrake_current_o, 16'h0032);
		wait_f(16'h00C8);
		run_i <= 1'b0;
		for (k = 0; k < 1000 && dcbrake_o !== 1'b1; k++) @(posedge clk_i) #1;
		chk(16'(freq_o <= 16'h001F && freq_o >= 16'h001D), 16'h0001);
		// Restart, limit, fault reset, refused code, power cycle
		wr(A_DCSTART, 16'h0000);
		wr(A_RLIM, 16'h0001);
		wr(A_MFOSEL, 16'h0001);
		run_i <= 1'b1;
		cyc(5);
		flt(FLT_OC);
		chk(16'(multifunc_o), 16'h0001);
		rdc(A_RCNT, 16'h0001);
		for (k = 0; k < 300 && multifunc_o !== 1'b0; k++) @(posedge clk_i) #1;
		cyc(5);
		flt(FLT_GF);
		chk(16'(trip_o), 16'h0001);
		chk(16'(multifunc_o), 16'h0000);
		fault_reset_i <= 1'b1;
		cyc(1);
		fault_reset_i <= 1'b0;
		cyc(1);
		chk(16'(trip_o), 16'h0000);
		rdc(A_RCNT, 16'h0000);
		flt(4'h7);
		chk(16'(trip_o), 16'h0001);
		fault_reset_i <= 1'b1;
		cyc(1);
		fault_reset_i <= 1'b0;
		cyc(3);
		flt(FLT_OV);
		rdc(A_RCNT, 16'h0001);
		rst_i <= 1'b1;
		cyc(2);
		rst_i <= 1'b0;
		rdc(A_RCNT, 16'h0000);
		end_sim();
	end
endmodule

// [inc/dfr_pkg.sv]
// Purpose: Shared constants of the drive frequency reference and protection block.
// Assumes: Frequencies in 0.1 Hz, times in 0.1 s, levels in percent unless noted.
// Notes: Parameter words are 16 bits wide and sit at word addresses.
package dfr_pkg;
	localparam int NPRM = 23;
	localparam logic [7:0] A_VFSEL = 8'h00;
	localparam logic [7:0] A_FMAX = 8'h01;
	localparam logic [7:0] A_FVMAX = 8'h02;
	localparam logic [7:0] A_FMID = 8'h03;
	localparam logic [7:0] A_VMID = 8'h04;
	localparam logic [7:0] A_FMIN = 8'h05;
	localparam logic [7:0] A_IRATED = 8'h06;
	localparam logic [7:0] A_INOLOAD = 8'h07;
	localparam logic [7:0] A_SLIP = 8'h08;
	localparam logic [7:0] A_DCFREQ = 8'h09;
	localparam logic [7:0] A_DCCUR = 8'h0A;
	localparam logic [7:0] A_DCSTOP = 8'h0B;
	localparam logic [7:0] A_DCSTART = 8'h0C;
	localparam logic [7:0] A_UB = 8'h0D;
	localparam logic [7:0] A_LB = 8'h0E;
	localparam logic [7:0] A_JP1 = 8'h0F;
	localparam logic [7:0] A_JW = 8'h12;
	localparam logic [7:0] A_RLIM = 8'h13;
	localparam logic [7:0] A_ASTALL = 8'h14;
	localparam logic [7:0] A_RSTALL = 8'h15;
	localparam logic [7:0] A_MFOSEL = 8'h16;
	localparam logic [7:0] A_STATUS = 8'h20;
	localparam logic [7:0] A_OUTF = 8'h21;
	localparam logic [7:0] A_RCNT = 8'h22;
	// Reset values, index 22 first down to index 0
	localparam logic [NPRM-1:0][15:0] PRM_RST = {
		16'h0000, 16'h00AA, 16'h00AA, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0032, 16'h000F, 16'h0000,
		16'h0064, 16'h001E, 16'h000F, 16'h000F, 16'h0258, 16'h0258, 16'h0000};
	localparam logic [3:0] VF_USER = 4'hF;
	localparam logic [15:0] PRESET_F50 = 16'h01F4;
	localparam logic [15:0] PRESET_F60 = 16'h0258;
	localparam logic [15:0] PRESET_FMIN = 16'h000F;
	localparam logic [15:0] IRATED_LO = 16'h000A;
	localparam logic [15:0] IRATED_HI = 16'h00C8;
	localparam logic [15:0] INOLOAD_HI = 16'h0063;
	localparam logic [15:0] SLIP_HI = 16'h0063;
	localparam logic [15:0] PCT_FULL = 16'h0064;
	localparam logic [15:0] SLIP_FULL = 16'h03E8;
	// Fault codes presented with a fault pulse
	localparam logic [3:0] FLT_OC = 4'h1;
	localparam logic [3:0] FLT_GF = 4'h2;
	localparam logic [3:0] FLT_OV = 4'h3;
	// Multi-function output selections
	localparam logic [15:0] MFO_RUN = 16'h0000;
	localparam logic [15:0] MFO_RESTART = 16'h0001;
	localparam logic [15:0] MFO_TRIP = 16'h0002;
	// Timing: tenth-second tick, normal-run clear time, restart wait
	localparam int CLK_MHZ = 250;
	localparam int TICK_MS = 100;
	localparam int TICK_CYC = CLK_MHZ * 1000 * TICK_MS;
	localparam int OK_MIN = 10;
	localparam logic [15:0] OK_TICKS = 16'(OK_MIN * 60 * 1000 / TICK_MS);
	localparam logic [15:0] RESTART_TICKS = 16'h0005;
	localparam int RAMP_CYC = 2500;
	typedef enum logic [2:0] {
		ST_IDLE, ST_DCSTART, ST_RUN, ST_DCSTOP, ST_RESTART, ST_TRIP
	} dfr_state_type;
endpackage
